// ==== src/cep_prioritizer.sv ====
`timescale 1ns/1ps
module cep_prioritizer (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic        RESET_INPUT_PIN_N,
  input  wire logic        NMI_PIN,
  input  wire logic [3:0]  ENCODED_INTERRUPT_LEVEL_PINS,
  input  wire logic        IRQ_MODE,
  input  wire logic        USER_BREAK_REQ,
  input  wire logic        DEBUG_INTERFACE_INTERRUPT,
  input  wire logic        PERI_REQ,
  input  wire logic [3:0]  PERI_LEVEL,
  input  wire logic [7:0]  PERI_VEC,
  input  wire logic        CPU_ADDR_ERR,
  input  wire logic        DMA_ADDR_ERR,
  input  wire logic        DEC_VALID,
  input  wire logic [3:0]  DEC_KIND,
  input  wire logic        DEC_IN_SLOT,
  input  wire logic        TRAP_EXEC,
  input  wire logic [7:0]  TRAP_VEC,
  input  wire logic        EXEC_DONE,
  input  wire logic [31:0] CUR_PC,
  input  wire logic [31:0] STATUS_WORD,
  input  wire logic [31:0] STACK_POINTER_REGISTER,
  input  wire logic [31:0] VECTOR_BASE,
  output logic             MEM_REQ,
  output logic             MEM_WE,
  output logic [31:0]      MEM_ADDR,
  output logic [31:0]      MEM_WDATA,
  input  wire logic [31:0] MEM_RDATA,
  input  wire logic        MEM_ACK,
  output logic             EXC_BUSY,
  output logic             EXC_ACCEPT,
  output logic [7:0]       EXC_VECTOR,
  output logic             LOAD_CTX,
  output logic [31:0]      NEW_PC,
  output logic [31:0]      NEW_SP,
  output logic             LOAD_VECTOR_BASE,
  output logic [31:0]      NEW_VECTOR_BASE,
  output logic             LOAD_MASK,
  output logic [3:0]       NEW_INTERRUPT_MASK_FIELD
);
  import cep_pkg::*;

  cep_src_if src ();
  cep_picker u_pick (.p(src));

  // ==========================================================
  // Pin synchronisers and edge detection
  logic [5:0] sync_a;
  logic [5:0] sync_b;
  logic [1:0] sync_c;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sync_a <= SYNC_INIT;
      sync_b <= SYNC_INIT;
      sync_c <= 2'h2;
    end else begin
      sync_a <= {RESET_INPUT_PIN_N, NMI_PIN, ENCODED_INTERRUPT_LEVEL_PINS};
      sync_b <= sync_a;
      sync_c <= sync_b[5:4];
    end
  end
  logic rst_rise;
  logic nmi_rise;
  logic nmi_lvl;
  assign nmi_lvl  = sync_b[4];
  assign rst_rise = sync_b[5] & ~sync_c[1];
  assign nmi_rise = sync_b[4] & ~sync_c[0];

  // ==========================================================
  // Decode helpers
  function automatic logic pc_mod(input logic [3:0] k);
    pc_mod = (k == KIND_JUMP) || (k == KIND_CALL) || (k == KIND_BRA) ||
             (k == KIND_CBR) || (k == KIND_CBR_D) || (k == KIND_BRA_R) ||
             (k == KIND_RET) || (k == KIND_RTE) || (k == KIND_TRAP);
  endfunction : pc_mod

  // ==========================================================
  // External interrupt pins, active low
  logic [3:0] irl_lvl;
  logic [3:0] ext_lvl;
  logic [7:0] ext_vec;
  logic [7:0] irq_vec;
  logic       irq_hit;
  logic       ext_req;
  always_comb begin
    irq_hit = 1'b0;
    irq_vec = VEC_EXT_BASE;
    // four independent requests or encoded level
    for (int i = 3; i >= 0; i--) begin
      if (!sync_b[i]) begin
        irq_hit = 1'b1;
        irq_vec = VEC_EXT_BASE + 8'(i);
      end
    end
    irl_lvl = ~sync_b[3:0];
    ext_lvl = IRQ_MODE ? LVL_IRQ : irl_lvl;
    ext_vec = IRQ_MODE ? irq_vec : VEC_EXT_BASE + {5'h00, irl_lvl[3:1]};
    ext_req = IRQ_MODE ? irq_hit : (irl_lvl != 4'h0);
  end

  // ==========================================================
  // Pending flags and source requests
  cep_state_t state;
  cep_state_t next_state;
  logic por_pend, mr_pend, nmi_pend, cae_pend, dae_pend;
  logic next_por, next_mr, next_nmi, next_cae, next_dae;
  logic [3:0] mask;
  logic idle, late, early, slot_bad;
  assign mask  = STATUS_WORD[SR_MASK_LSB +: 4];
  assign idle  = (state == ST_IDLE);
  assign late  = idle & EXEC_DONE;
  assign early = idle & DEC_VALID;
  assign slot_bad = DEC_IN_SLOT & ((DEC_KIND == KIND_UNDEF) | pc_mod(DEC_KIND));

  always_comb begin
    // power-on on rise with NMI high
    next_por = (por_pend & ~src.win_sel[SEL_POR]) | (rst_rise & nmi_lvl);
    // manual on rise with NMI low
    next_mr  = (mr_pend & ~src.win_sel[SEL_MR]) | (rst_rise & ~nmi_lvl);
    next_nmi = (nmi_pend & ~src.win_sel[SEL_NMI]) | nmi_rise;
    next_cae = (cae_pend & ~src.win_sel[SEL_CPU_AE]) | CPU_ADDR_ERR;
    next_dae = (dae_pend & ~src.win_sel[SEL_DMA_AE]) | DMA_ADDR_ERR;
  end
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      {por_pend, mr_pend, nmi_pend, cae_pend, dae_pend} <= 5'h00;
    end else begin
      {por_pend, mr_pend, nmi_pend, cae_pend, dae_pend} <=
        {next_por, next_mr, next_nmi, next_cae, next_dae};
    end
  end

  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      src.lvl[i] = 4'h0;
    end
    src.req[SEL_POR]     = por_pend;
    src.req[SEL_MR]      = mr_pend;
    src.req[SEL_CPU_AE]  = late & cae_pend;
    src.req[SEL_DMA_AE]  = late & dae_pend;
    // interrupt ranking by slot, gated by mask except NMI
    src.req[SEL_NMI]     = late & nmi_pend;
    src.req[SEL_UBRK]    = late & USER_BREAK_REQ & (LVL_UBRK > mask);
    src.req[SEL_DBG]     = late & DEBUG_INTERFACE_INTERRUPT & (LVL_DBG > mask);
    src.req[SEL_EXT]     = late & ext_req & (ext_lvl > mask);
    src.req[SEL_PERI]    = late & PERI_REQ & (PERI_LEVEL > mask);
    src.req[SEL_TRAP]    = idle & TRAP_EXEC;
    src.req[SEL_GEN_ILL] = early & ~DEC_IN_SLOT & (DEC_KIND == KIND_UNDEF);
    src.req[SEL_SLOT]    = early & slot_bad;
    src.vec[SEL_POR]     = VEC_POR;
    src.vec[SEL_MR]      = VEC_MR;
    src.vec[SEL_CPU_AE]  = VEC_CPU_AE;
    src.vec[SEL_DMA_AE]  = VEC_DMA_AE;
    src.vec[SEL_NMI]     = VEC_NMI;
    src.vec[SEL_UBRK]    = VEC_UBRK;
    src.vec[SEL_DBG]     = VEC_DBG;
    src.vec[SEL_EXT]     = ext_vec;
    src.vec[SEL_PERI]    = PERI_VEC;
    src.vec[SEL_TRAP]    = TRAP_VEC;
    src.vec[SEL_GEN_ILL] = VEC_GEN_ILL;
    src.vec[SEL_SLOT]    = VEC_SLOT_ILL;
    src.lvl[SEL_NMI]     = LVL_NMI;
    src.lvl[SEL_UBRK]    = LVL_UBRK;
    src.lvl[SEL_DBG]     = LVL_DBG;
    src.lvl[SEL_EXT]     = ext_lvl;
    src.lvl[SEL_PERI]    = PERI_LEVEL;
  end

  // ==========================================================
  // Handling sequencer
  logic        win_rst, win_int;
  logic        rst_k, int_k, next_rst_k, next_int_k;
  logic [7:0]  vec_k, next_vec_k;
  logic [3:0]  lvl_k, next_lvl_k;
  logic [31:0] sp_w, next_sp_w, pc_sv, next_pc_sv, sr_sv, next_sr_sv;
  logic        next_req, next_we, next_acc, next_ld, next_ldv, next_ldm;
  logic [31:0] next_addr, next_wdata, next_pc, next_sp, next_vbr;
  logic [7:0]  next_evec;
  logic [3:0]  next_mask;
  assign win_rst  = src.win_sel[SEL_POR] | src.win_sel[SEL_MR];
  assign win_int  = |src.win_sel[SEL_PERI:SEL_NMI];
  assign EXC_BUSY = ~idle;

  always_comb begin
    next_state = state;
    {next_rst_k, next_int_k, next_vec_k, next_lvl_k} =
      {rst_k, int_k, vec_k, lvl_k};
    {next_sp_w, next_pc_sv, next_sr_sv} = {sp_w, pc_sv, sr_sv};
    {next_req, next_we, next_addr, next_wdata} =
      {MEM_REQ, MEM_WE, MEM_ADDR, MEM_WDATA};
    {next_pc, next_sp, next_vbr, next_mask, next_evec} =
      {NEW_PC, NEW_SP, NEW_VECTOR_BASE, NEW_INTERRUPT_MASK_FIELD, EXC_VECTOR};
    {next_acc, next_ld, next_ldv, next_ldm} = 4'h0;
    if (src.any && win_rst) begin
      next_state = ST_VEC;
      next_rst_k = 1'b1;
      next_int_k = 1'b0;
      next_acc   = 1'b1;
      next_evec  = src.win_vec;
      next_req   = 1'b1;
      next_we    = 1'b0;
      next_addr  = src.win_sel[SEL_POR] ? POR_PC_ADDR : MR_PC_ADDR;
      next_sp_w  = src.win_sel[SEL_POR] ? POR_SP_ADDR : MR_SP_ADDR;
    end else begin
      unique case (state)
        ST_IDLE: if (src.any) begin
          next_state = ST_PUSH_SR;
          {next_rst_k, next_int_k} = {1'b0, win_int};
          {next_vec_k, next_lvl_k} = {src.win_vec, src.win_lvl};
          {next_pc_sv, next_sr_sv} = {CUR_PC, STATUS_WORD};
          next_acc   = 1'b1;
          next_evec  = src.win_vec;
          next_sp_w  = STACK_POINTER_REGISTER - STACK_STEP;
          next_req   = 1'b1;
          next_we    = 1'b1;
          next_addr  = STACK_POINTER_REGISTER - STACK_STEP;
          next_wdata = STATUS_WORD;
        end
        ST_PUSH_SR: if (MEM_ACK) begin
          next_state = ST_PUSH_PC;
          next_sp_w  = sp_w - STACK_STEP;
          next_addr  = sp_w - STACK_STEP;
          next_wdata = pc_sv;
        end
        ST_PUSH_PC: if (MEM_ACK) begin
          next_state = ST_VEC;
          next_we    = 1'b0;
          next_addr  = VECTOR_BASE + {22'h000000, vec_k, 2'h0};
        end
        ST_VEC: if (MEM_ACK) begin
          next_pc    = MEM_RDATA;
          next_sp    = sp_w;
          next_addr  = sp_w;
          next_req   = rst_k;
          next_state = rst_k ? ST_RST_SP : ST_DONE;
        end
        ST_RST_SP: if (MEM_ACK) begin
          next_sp    = MEM_RDATA;
          next_req   = 1'b0;
          next_state = ST_DONE;
        end
        ST_DONE: begin
          next_state = ST_IDLE;
          next_ld    = 1'b1;
          next_ldv   = rst_k;
          next_vbr   = VBR_RESET;
          next_ldm   = rst_k | int_k;
          next_mask  = rst_k ? MASK_ALL : lvl_k;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state <= ST_IDLE;
      {rst_k, int_k, vec_k, lvl_k} <= '0;
      {sp_w, pc_sv, sr_sv} <= '0;
      {MEM_REQ, MEM_WE, MEM_ADDR, MEM_WDATA} <= '0;
      {NEW_PC, NEW_SP, NEW_VECTOR_BASE, NEW_INTERRUPT_MASK_FIELD} <= '0;
      EXC_VECTOR <= 8'h00;
      {EXC_ACCEPT, LOAD_CTX, LOAD_VECTOR_BASE, LOAD_MASK} <= 4'h0;
    end else begin
      state <= next_state;
      {rst_k, int_k, vec_k, lvl_k} <=
        {next_rst_k, next_int_k, next_vec_k, next_lvl_k};
      {sp_w, pc_sv, sr_sv} <= {next_sp_w, next_pc_sv, next_sr_sv};
      {MEM_REQ, MEM_WE, MEM_ADDR, MEM_WDATA} <=
        {next_req, next_we, next_addr, next_wdata};
      {NEW_PC, NEW_SP, NEW_VECTOR_BASE, NEW_INTERRUPT_MASK_FIELD} <=
        {next_pc, next_sp, next_vbr, next_mask};
      EXC_VECTOR <= next_evec;
      {EXC_ACCEPT, LOAD_CTX, LOAD_VECTOR_BASE, LOAD_MASK} <=
        {next_acc, next_ld, next_ldv, next_ldm};
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_por_edge: assert property (rst_rise && nmi_lvl |=> por_pend)
    else $error("power-on reset not pending after pin rise");
  a_mr_edge: assert property (rst_rise && !nmi_lvl |=> mr_pend)
    else $error("manual reset not pending after pin rise");
  a_reset_wins: assert property (
    (src.req[SEL_POR] || src.req[SEL_MR]) |-> win_rst)
    else $error("reset lost priority");
  a_por_over_mr: assert property (
    src.req[SEL_POR] && src.req[SEL_MR] |-> src.win_sel[SEL_POR])
    else $error("manual reset beat power-on");
  a_cpu_ae_first: assert property (
    src.req[SEL_CPU_AE] && src.req[SEL_DMA_AE] && !win_rst
    |-> src.win_sel[SEL_CPU_AE])
    else $error("DMA error beat CPU error");
  a_nmi_over_int: assert property (
    src.req[SEL_NMI] && (|src.req[SEL_PERI:SEL_UBRK])
    |-> !(|src.win_sel[SEL_PERI:SEL_UBRK]))
    else $error("interrupt beat NMI");
  a_trap_order: assert property (
    src.req[SEL_TRAP] && src.req[SEL_SLOT] |-> !src.win_sel[SEL_SLOT])
    else $error("slot illegal beat trap");
  a_wait_exec: assert property (
    (|src.win_sel[SEL_PERI:SEL_CPU_AE]) |-> EXEC_DONE)
    else $error("error or interrupt taken before finish");
  a_por_fetch: assert property (
    src.win_sel[SEL_POR] |=> MEM_REQ && !MEM_WE && MEM_ADDR == POR_PC_ADDR
    && EXC_ACCEPT)
    else $error("power-on vector fetch wrong");
  a_por_sp: assert property (
    state == ST_VEC && rst_k && MEM_ACK && EXC_VECTOR == VEC_POR && !src.any
    |=> MEM_REQ && !MEM_WE && MEM_ADDR == POR_SP_ADDR)
    else $error("power-on stack fetch wrong");
  a_reset_tail: assert property (
    LOAD_VECTOR_BASE |-> LOAD_MASK && LOAD_CTX && NEW_VECTOR_BASE == VBR_RESET
    && NEW_INTERRUPT_MASK_FIELD == MASK_ALL)
    else $error("reset tail wrong");
  a_push_pc: assert property (
    state == ST_PUSH_SR && MEM_ACK && !src.any
    |=> MEM_WE && MEM_WDATA == pc_sv && MEM_ADDR == $past(MEM_ADDR) - 4)
    else $error("PC push wrong");
  a_handler_addr: assert property (
    state == ST_PUSH_PC && MEM_ACK && !src.any
    |=> !MEM_WE && MEM_ADDR == VECTOR_BASE + {22'h000000, vec_k, 2'h0})
    else $error("handler address wrong");

  c_por: cover property (src.win_sel[SEL_POR] ##[1:40] LOAD_VECTOR_BASE);
  c_irq: cover property (src.win_sel[SEL_EXT] ##[1:60] LOAD_MASK);
  c_slot: cover property (src.win_sel[SEL_SLOT] ##[1:60] LOAD_CTX);
endmodule : cep_prioritizer

// ==== include/cep_pkg.sv ====
// Summary of operation
// - Four source classes start exception handling
// - Reset, address error, interrupt, instruction order
// - Power-on reset beats manual reset
// - CPU address error beats DMA error
// - NMI, break, debug, external, peripheral order
// - Trap, general illegal, slot illegal order
// - Reset pin rise, NMI high: power-on
// - Reset pin rise, NMI low: manual
// - Errors, interrupts wait for execution finish
// - Trap handling starts when trap executes
// - Undefined code outside slot: general illegal
// - Undefined or PC-writing slot: slot illegal
// - Jumps, calls, branches, returns, trap write PC
// - Reset loads PC, SP from vectors
// - Reset clears vector base, mask all ones
// - Push status and PC; interrupts set mask
// - Handler address is base plus vector times four
package cep_pkg;
  // ==========================================================
  // Source slots, lowest index has highest priority
  localparam int NSRC        = 12;
  localparam int SEL_POR     = 0;
  localparam int SEL_MR      = 1;
  localparam int SEL_CPU_AE  = 2;
  localparam int SEL_DMA_AE  = 3;
  localparam int SEL_NMI     = 4;
  localparam int SEL_UBRK    = 5;
  localparam int SEL_DBG     = 6;
  localparam int SEL_EXT     = 7;
  localparam int SEL_PERI    = 8;
  localparam int SEL_TRAP    = 9;
  localparam int SEL_GEN_ILL = 10;
  localparam int SEL_SLOT    = 11;
  // ==========================================================
  // Vector numbers
  localparam logic [7:0] VEC_POR      = 8'h00;
  localparam logic [7:0] VEC_MR       = 8'h02;
  localparam logic [7:0] VEC_GEN_ILL  = 8'h04;
  localparam logic [7:0] VEC_SLOT_ILL = 8'h06;
  localparam logic [7:0] VEC_CPU_AE   = 8'h09;
  localparam logic [7:0] VEC_DMA_AE   = 8'h0A;
  localparam logic [7:0] VEC_NMI      = 8'h0B;
  localparam logic [7:0] VEC_UBRK     = 8'h0C;
  localparam logic [7:0] VEC_DBG      = 8'h0D;
  localparam logic [7:0] VEC_EXT_BASE = 8'h40;
  // ==========================================================
  // Reset vector offsets and reset values
  localparam logic [31:0] POR_PC_ADDR = 32'h00000000;
  localparam logic [31:0] POR_SP_ADDR = 32'h00000004;
  localparam logic [31:0] MR_PC_ADDR  = 32'h00000008;
  localparam logic [31:0] MR_SP_ADDR  = 32'h0000000C;
  localparam logic [31:0] VBR_RESET   = 32'h00000000;
  localparam logic [31:0] STACK_STEP  = 32'h00000004;
  localparam logic [3:0]  MASK_ALL    = 4'hF;
  localparam int          SR_MASK_LSB = 4;
  // ==========================================================
  // Fixed levels of NMI, break, debug and IRQ-mode pin sources
  localparam logic [3:0] LVL_NMI  = 4'hF;
  localparam logic [3:0] LVL_UBRK = 4'hF;
  localparam logic [3:0] LVL_DBG  = 4'hF;
  localparam logic [3:0] LVL_IRQ  = 4'hF;
  // Pin synchroniser state after reset: reset pin high, pins idle
  localparam logic [5:0] SYNC_INIT = 6'h2F;
  // ==========================================================
  // Instruction kinds reported by the decoder
  localparam logic [3:0] KIND_OTHER  = 4'h0;
  localparam logic [3:0] KIND_JUMP   = 4'h1;
  localparam logic [3:0] KIND_CALL   = 4'h2;
  localparam logic [3:0] KIND_BRA    = 4'h3;
  localparam logic [3:0] KIND_CBR    = 4'h4;
  localparam logic [3:0] KIND_CBR_D  = 4'h5;
  localparam logic [3:0] KIND_BRA_R  = 4'h6;
  localparam logic [3:0] KIND_RET    = 4'h7;
  localparam logic [3:0] KIND_RTE    = 4'h8;
  localparam logic [3:0] KIND_TRAP   = 4'h9;
  localparam logic [3:0] KIND_UNDEF  = 4'hF;
  // ==========================================================
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_PUSH_SR = 6'h02,
    ST_PUSH_PC = 6'h04,
    ST_VEC     = 6'h08,
    ST_RST_SP  = 6'h10,
    ST_DONE    = 6'h20
  } cep_state_t;
endpackage : cep_pkg

// ==== include/cep_src_if.sv ====
`timescale 1ns/1ps
interface cep_src_if;
  import cep_pkg::*;
  logic [NSRC-1:0] req;
  logic [7:0]      vec [NSRC];
  logic [3:0]      lvl [NSRC];
  logic            any;
  logic [NSRC-1:0] win_sel;
  logic [7:0]      win_vec;
  logic [3:0]      win_lvl;
  modport pick (input req, vec, lvl, output any, win_sel, win_vec, win_lvl);
  modport ctrl (output req, vec, lvl, input any, win_sel, win_vec, win_lvl);
endinterface : cep_src_if

// ==== src/cep_picker.sv ====
`timescale 1ns/1ps
module cep_picker (
  cep_src_if.pick p
);
  import cep_pkg::*;
  // ==========================================================
  // Fixed priority: scan from lowest priority so the top wins
  always_comb begin
    p.any     = 1'b0;
    p.win_sel = '0;
    p.win_vec = 8'h00;
    p.win_lvl = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (p.req[i]) begin
        p.any     = 1'b1;
        p.win_sel = '0;
        p.win_sel[i] = 1'b1;
        p.win_vec = p.vec[i];
        p.win_lvl = p.lvl[i];
      end
    end
  end
endmodule : cep_picker

// ==== test/cep_mem_model.sv ====
`timescale 1ns/1ps
module cep_mem_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic [31:0] addr,
  input  wire logic [3:0]  lat,
  output logic             ack,
  output logic [31:0]      rdata
);
  logic [3:0]  cnt;
  logic [31:0] last;
  // ==========================================================
  // Word slave: ack lat+1 cycles after a request is first seen
  always @(posedge clk) begin
    last <= addr;
    if (rst) begin
      cnt   <= 4'h0;
      ack   <= 1'b0;
      rdata <= 32'hA5A5A5A5;
    end else if (!req || ack || addr != last) begin
      // New or dropped request restarts; bus shows junk
      cnt   <= 4'h0;
      ack   <= 1'b0;
      rdata <= ~rdata;
    end else if (cnt == lat) begin
      ack   <= 1'b1;
      rdata <= ~addr;
    end else begin
      cnt   <= cnt + 4'h1;
      rdata <= ~rdata;
    end
  end
endmodule : cep_mem_model

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [8:0] src;
    logic [3:0] kind;
    logic [3:0] pins;
    logic       mode;
    logic [3:0] mask;
    logic       acc;
    logic [7:0] vec;
    logic [3:0] lvl;
  } cep_row_t;
  logic CLK, SYS_RST, RESET_INPUT_PIN_N, NMI_PIN, IRQ_MODE, PERI_REQ;
  logic USER_BREAK_REQ, DEBUG_INTERFACE_INTERRUPT, CPU_ADDR_ERR;
  logic DMA_ADDR_ERR, DEC_VALID, DEC_IN_SLOT, TRAP_EXEC, EXEC_DONE;
  logic MEM_REQ, MEM_WE, MEM_ACK, EXC_BUSY, EXC_ACCEPT, LOAD_CTX;
  logic LOAD_VECTOR_BASE, LOAD_MASK;
  logic [3:0]  ENCODED_INTERRUPT_LEVEL_PINS, PERI_LEVEL, DEC_KIND, lat;
  logic [3:0]  NEW_INTERRUPT_MASK_FIELD;
  logic [7:0]  PERI_VEC, TRAP_VEC, EXC_VECTOR;
  logic [31:0] CUR_PC, STATUS_WORD, STACK_POINTER_REGISTER, VECTOR_BASE;
  logic [31:0] MEM_ADDR, MEM_WDATA, MEM_RDATA, NEW_PC, NEW_SP;
  logic [31:0] NEW_VECTOR_BASE;
  logic [64:0] mlog [$];
  int          n_mismatch = 0;
  int          total_checks = 0;
  // src bits: cpu ae, dma ae, nmi, break, debug, peri, trap, dec, slot
  cep_row_t rows [16] = '{
    '{9'h04F, 4'h0, 4'hF, 1'b0, 4'h0, 1'b1, 8'h09, 4'h0},
    '{9'h000, 4'h0, 4'hF, 1'b0, 4'h0, 1'b1, 8'h0A, 4'h0},
    '{9'h000, 4'h0, 4'hF, 1'b0, 4'h0, 1'b1, 8'h0B, 4'hF},
    '{9'h0F8, 4'hF, 4'h0, 1'b0, 4'h0, 1'b1, 8'h0C, 4'hF},
    '{9'h030, 4'h0, 4'h0, 1'b0, 4'h0, 1'b1, 8'h0D, 4'hF},
    '{9'h020, 4'h0, 4'h6, 1'b0, 4'h0, 1'b1, 8'h44, 4'h9},
    '{9'h000, 4'h0, 4'hC, 1'b0, 4'h3, 1'b0, 8'h00, 4'h0},
    '{9'h000, 4'h0, 4'hC, 1'b0, 4'h2, 1'b1, 8'h41, 4'h3},
    '{9'h000, 4'h0, 4'h9, 1'b1, 4'h0, 1'b1, 8'h41, 4'hF},
    '{9'h000, 4'h0, 4'h7, 1'b1, 4'h0, 1'b1, 8'h43, 4'hF},
    '{9'h060, 4'h0, 4'hF, 1'b0, 4'h0, 1'b1, 8'h70, 4'h5},
    '{9'h0C0, 4'hF, 4'hF, 1'b0, 4'h0, 1'b1, 8'h21, 4'h0},
    '{9'h080, 4'hF, 4'hF, 1'b0, 4'h0, 1'b1, 8'h04, 4'h0},
    '{9'h180, 4'hF, 4'hF, 1'b0, 4'h0, 1'b1, 8'h06, 4'h0},
    '{9'h080, 4'h1, 4'hF, 1'b0, 4'h0, 1'b0, 8'h00, 4'h0},
    '{9'h180, 4'h0, 4'hF, 1'b0, 4'h0, 1'b0, 8'h00, 4'h0}
  };

  cep_prioritizer u_cep_prioritizer (.*);
  cep_mem_model u_cep_mem_model (
    .clk   (CLK),
    .rst   (SYS_RST),
    .req   (MEM_REQ),
    .addr  (MEM_ADDR),
    .lat   (lat),
    .ack   (MEM_ACK),
    .rdata (MEM_RDATA)
  );

  always #10 CLK = ~CLK;
  always @(posedge CLK) begin
    if (MEM_REQ === 1'b1 && MEM_ACK === 1'b1)
      mlog.push_back({MEM_WE, MEM_ADDR, MEM_WDATA});
  end

  // ==========================================================
  // Helpers
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic wait_ctx;
    int n;
    n = 0;
    do begin
      @(posedge CLK);
      #1 n++;
    end while (LOAD_CTX !== 1'b1 && n < 200);
    check(LOAD_CTX === 1'b1, "no context load");
  endtask : wait_ctx

  task automatic run_row(input cep_row_t r, input int id);
    logic [31:0] va;
    va = VECTOR_BASE + {22'h0, r.vec, 2'b00};
    mlog.delete();
    @(posedge CLK);
    lat <= id[3:0];
    CUR_PC <= 32'h1000 + 32'(id);
    CPU_ADDR_ERR <= r.src[0];
    DMA_ADDR_ERR <= r.src[1];
    NMI_PIN <= r.src[2];
    USER_BREAK_REQ <= r.src[3];
    DEBUG_INTERFACE_INTERRUPT <= r.src[4];
    PERI_REQ <= r.src[5];
    ENCODED_INTERRUPT_LEVEL_PINS <= r.pins;
    IRQ_MODE <= r.mode;
    STATUS_WORD <= {24'h0, r.mask, 4'h0};
    @(posedge CLK);
    CPU_ADDR_ERR <= 1'b0;
    DMA_ADDR_ERR <= 1'b0;
    repeat (3) begin
      @(posedge CLK);
      #1 check(EXC_BUSY === 1'b0, "taken early");
    end
    @(posedge CLK);
    EXEC_DONE <= 1'b1;
    TRAP_EXEC <= r.src[6];
    DEC_VALID <= r.src[7];
    DEC_KIND <= r.kind;
    DEC_IN_SLOT <= r.src[8];
    @(posedge CLK);
    #1 check(EXC_ACCEPT === r.acc, "acceptance");
    if (r.acc) check(EXC_VECTOR === r.vec, "vector");
    @(posedge CLK);
    {EXEC_DONE, TRAP_EXEC, DEC_VALID, DEC_IN_SLOT} <= 4'h0;
    {NMI_PIN, USER_BREAK_REQ, DEBUG_INTERFACE_INTERRUPT} <= 3'h0;
    PERI_REQ <= 1'b0;
    ENCODED_INTERRUPT_LEVEL_PINS <= 4'hF;
    if (r.acc) begin
      wait_ctx();
      check(NEW_PC === ~va, "handler");
      check(NEW_SP === STACK_POINTER_REGISTER - 32'h8, "sp");
      check(LOAD_MASK === (r.lvl != 4'h0), "mask load");
      if (r.lvl != 4'h0)
        check(NEW_INTERRUPT_MASK_FIELD === r.lvl, "mask");
      check(mlog[0] === {1'b1, STACK_POINTER_REGISTER - 32'h4,
                         STATUS_WORD}, "push status");
      check(mlog[1] === {1'b1, STACK_POINTER_REGISTER - 32'h8,
                         CUR_PC}, "push pc");
      check(mlog[2][64:32] === {1'b0, va}, "vector read");
    end
    $display("row %0d done", id);
  endtask : run_row

  task automatic pin_reset(input logic nmi);
    logic [31:0] pa;
    int          n;
    pa = nmi ? 32'h0 : 32'h8;
    n = 0;
    @(posedge CLK);
    NMI_PIN <= nmi;
    RESET_INPUT_PIN_N <= 1'b0;
    repeat (4) @(posedge CLK);
    RESET_INPUT_PIN_N <= 1'b1;
    do begin
      @(posedge CLK);
      #1 n++;
    end while (EXC_ACCEPT !== 1'b1 && n < 8);
    mlog.delete();
    check(EXC_VECTOR === {6'h0, ~nmi, 1'b0}, "reset kind");
    wait_ctx();
    check(mlog[0][64:32] === {1'b0, pa}, "pc fetch");
    check(mlog[1][64:32] === {1'b0, pa + 32'h4}, "sp fetch");
    check(NEW_PC === ~pa && NEW_SP === ~(pa + 32'h4), "ctx");
    check(LOAD_VECTOR_BASE === 1'b1 && NEW_VECTOR_BASE === 32'h0,
          "base");
    check(LOAD_MASK === 1'b1 && NEW_INTERRUPT_MASK_FIELD === 4'hF,
          "mask");
    $display("reset test done");
  endtask : pin_reset

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  // ==========================================================
  // Main sequence
  initial begin
    CLK = 1'b0;
    {SYS_RST, RESET_INPUT_PIN_N} <= 2'b11;
    {NMI_PIN, IRQ_MODE, USER_BREAK_REQ, PERI_REQ} <= 4'h0;
    {DEBUG_INTERFACE_INTERRUPT, CPU_ADDR_ERR, DMA_ADDR_ERR} <= 3'h0;
    {DEC_VALID, DEC_IN_SLOT, TRAP_EXEC, EXEC_DONE} <= 4'h0;
    ENCODED_INTERRUPT_LEVEL_PINS <= 4'hF;
    DEC_KIND <= 4'h0;
    PERI_LEVEL <= 4'h5;
    PERI_VEC <= 8'h70;
    TRAP_VEC <= 8'h21;
    lat <= 4'h0;
    CUR_PC <= 32'h1000;
    STATUS_WORD <= 32'h0;
    STACK_POINTER_REGISTER <= 32'h8000;
    VECTOR_BASE <= 32'h4000;
    repeat (16) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    #1 check(EXC_BUSY === 1'b0 && MEM_REQ === 1'b0, "reset state");
    for (int i = 0; i < 16; i++) run_row(rows[i], i);
    for (int k = 1; k < 10; k++)
      run_row(cep_row_t'{9'h180, 4'(k), 4'hF, 1'b0, 4'h0, 1'b1, 8'h06,
                         4'h0}, 20 + k);
    pin_reset(1'b0);
    // Pin reset while a break sequence waits on slow memory
    @(posedge CLK);
    lat <= 4'hA;
    USER_BREAK_REQ <= 1'b1;
    EXEC_DONE <= 1'b1;
    repeat (2) @(posedge CLK);
    USER_BREAK_REQ <= 1'b0;
    EXEC_DONE <= 1'b0;
    pin_reset(1'b1);
    results();
  end

  initial begin
    #200000;
    n_mismatch++;
    results();
  end
endmodule : tb_top
